// ==== verilog/uart_cfg.svh ====
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// register indexes on the plain register port
`define A_TRANSMIT_CONTROL_STATUS 3'h0
`define A_RECEIVE_CONTROL_STATUS 3'h1
`define A_BAUD  3'h2
`define A_RXDAT 3'h3
`define A_BRGL  3'h4
`define A_HIGH_BAUD_SELECT  3'h5
`define A_TXDAT 3'h6
// transmit_control_status
`define B_CLOCK_SOURCE 7
`define B_TX_NINE      6
`define B_TX_ENABLE    5
`define B_SYNC_MODE    4
`define B_BREAK_REQ    3
`define B_HIGH_BAUD    2
`define B_SHIFT_EMPTY  1
`define B_TX_NINTH     0
// receive_control_status
`define B_PORT_ENABLE  7
`define B_RX_NINE      6
`define B_SINGLE_RX    5
`define B_CONT_RX      4
`define B_ADDR_DETECT  3
`define B_OVERRUN_ERR  1
// baud_control
`define B_ABD_OVERFLOW 7
`define B_RX_IDLE      6
`define B_DATA_POL     5
`define B_CLK_TX_POL   4
`define B_BAUD_WIDTH   3
`define B_WAKEUP       1
`define B_AUTOBAUD     0
// reset values and software-writable masks
`define TXS_RST   8'h02
`define BDC_RST   8'h40
`define TXS_WMASK 8'hFD
`define RCS_WMASK 8'hF8
`define BDC_WMASK 8'h3B
// half-bit shift of (divisor+1)
`define SH_SLOW 5'h05
`define SH_MID  5'h03
`define SH_FAST 5'h01
// bit counts
`define NBITS8    4'h8
`define NBITS9    4'h9
`define FRAME8    4'hA
`define FRAME9    4'hB
`define FRAME_BRK 4'hE
// auto-baud: edge count at which the next falling edge (the fourth after the first) ends, extra divide shift
`define ABD_EDGES 3'h3
`define ABD_DIV   5'h04
`define FIFO_DEPTH 2'h2
`endif

// ==== verilog/uart_pkg.sv ====
package uart_pkg;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_WAKE  = 5'b01000,
    RX_ABD   = 5'b10000
  } rx_state_t;
  typedef struct packed {
    logic [7:0]       transmit_control_status;
    logic [7:0]       receive_control_status;
    logic [7:0]       baud_control;
    logic [7:0]       brg_lo;
    logic [7:0]       brg_hi;
    logic [1:0]       rx_s;
    logic             rx_p;
    logic [1:0]       ck_s;
    logic             ck_p;
    tx_state_t        tx_st;
    rx_state_t        rx_st;
    logic [21:0]      tx_cnt;
    logic [21:0]      rx_cnt;
    logic [13:0]      tx_sh;
    logic [3:0]       tx_bits;
    logic             tx_half;
    logic             brk;
    logic             s_rx;
    logic             tx_line;
    logic             ck_line;
    logic [7:0]       hold;
    logic             hv;
    logic [8:0]       rx_sh;
    logic [3:0]       rx_bits;
    logic             rx_half;
    logic [1:0][9:0]  fifo;
    logic [1:0]       fcnt;
    logic             wake;
    logic [25:0]      abd_cnt;
    logic [2:0]       abd_edges;
    logic [7:0]       rdata;
    logic             rflag;
    logic             ck_o;
    logic             ck_oe_n;
    logic             dt_o;
    logic             dt_oe_n;
  } state_t;
endpackage

// ==== verilog/serial_port.sv ====
`timescale 1ns/10ps
`include "uart_cfg.svh"
module serial_port
  import uart_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       rx_dt_in,
  input  wire logic       ck_in,
  output logic            dt_out,
  output logic            dt_oe_n,
  output logic            ck_out,
  output logic            ck_oe_n,
  output logic            receive_flag
);

  localparam state_t ST_RST = '{
    transmit_control_status: `TXS_RST,
    baud_control: `BDC_RST,
    tx_st: TX_IDLE,
    rx_st: RX_IDLE,
    ck_oe_n: 1'b1,
    dt_oe_n: 1'b1,
    default: '0
  };

  state_t      r;
  state_t      n;
  logic        port_enable;
  logic        syncm;
  logic        clock_source_select;
  logic        transmitter_enable;
  logic        continuous_receive_enable;
  logic        single_receive_enable;
  logic        address_detect_enable;
  logic        rx9;
  logic        tx9;
  logic        dpol;
  logic        ckp;
  logic        baud_width_select;
  logic        high_baud_select;
  logic        wakeup_enable;
  logic        autobaud_enable;
  logic        break_request;
  logic        overrun_error_flag;
  logic [4:0]  shamt;
  logic [15:0] divisor;
  logic [21:0] half_lim;
  logic [25:0] abd_q;
  logic [3:0]  nb_rx;
  logic [3:0]  nb_tx;
  logic        rx_dat;
  logic        rx_prev;
  logic        rx_fall;
  logic        rx_rise;
  logic        ck_now;
  logic        ck_rise;
  logic        ck_fall;
  logic        samp_ev;
  logic        shift_ev;
  logic        push;
  logic        pop;
  logic        drop;
  logic        tx_done;
  logic        sdone;
  logic        tx_tick;
  logic        rx_tick;
  logic [9:0]  ch;

  assign port_enable  = r.receive_control_status[`B_PORT_ENABLE];
  assign rx9   = r.receive_control_status[`B_RX_NINE];
  assign single_receive_enable  = r.receive_control_status[`B_SINGLE_RX];
  assign continuous_receive_enable  = r.receive_control_status[`B_CONT_RX];
  assign address_detect_enable = r.receive_control_status[`B_ADDR_DETECT];
  assign overrun_error_flag  = r.receive_control_status[`B_OVERRUN_ERR];
  assign clock_source_select  = r.transmit_control_status[`B_CLOCK_SOURCE];
  assign tx9   = r.transmit_control_status[`B_TX_NINE];
  assign transmitter_enable  = r.transmit_control_status[`B_TX_ENABLE];
  assign syncm = r.transmit_control_status[`B_SYNC_MODE];
  assign break_request = r.transmit_control_status[`B_BREAK_REQ];
  assign high_baud_select  = r.transmit_control_status[`B_HIGH_BAUD];
  assign dpol  = r.baud_control[`B_DATA_POL];
  assign ckp   = r.baud_control[`B_CLK_TX_POL];
  assign baud_width_select = r.baud_control[`B_BAUD_WIDTH];
  assign wakeup_enable   = r.baud_control[`B_WAKEUP];
  assign autobaud_enable = r.baud_control[`B_AUTOBAUD];

  // half-bit period of the baud generator
  assign shamt = syncm ? `SH_FAST :
                 baud_width_select ? (high_baud_select ? `SH_FAST : `SH_MID) :
                 (high_baud_select ? `SH_MID : `SH_SLOW);
  assign divisor = baud_width_select ? {r.brg_hi, r.brg_lo} : {8'h00, r.brg_lo};
  assign half_lim = (({6'h00, divisor} + 22'h000001) << shamt)
                    - 22'h000001;
  assign abd_q = (r.abd_cnt >> (shamt + `ABD_DIV)) - 26'h0000001;
  assign nb_rx = rx9 ? `NBITS9 : `NBITS8;
  assign nb_tx = tx9 ? `NBITS9 : `NBITS8;

  assign rx_dat  = r.rx_s[1] ^ dpol;
  assign rx_prev = r.rx_p ^ dpol;
  assign rx_fall = rx_prev & ~rx_dat;
  assign rx_rise = ~rx_prev & rx_dat;
  assign ck_now  = clock_source_select ? r.ck_line : r.ck_s[1];
  assign ck_rise = ck_now & ~r.ck_p;
  assign ck_fall = ~ck_now & r.ck_p;
  assign samp_ev  = ckp ? ck_rise : ck_fall;
  assign shift_ev = ckp ? ck_fall : ck_rise;

  always_comb begin
    n = r;
    push = 1'b0;
    pop = 1'b0;
    drop = 1'b0;
    tx_done = 1'b0;
    sdone = 1'b0;
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    ch = 10'h000;
    n.rx_s = {r.rx_s[0], rx_dt_in};
    n.rx_p = r.rx_s[1];
    n.ck_s = {r.ck_s[0], ck_in};
    n.ck_p = ck_now;
    if (r.tx_cnt >= half_lim) begin
      n.tx_cnt = 22'h000000;
      tx_tick = 1'b1;
    end else begin
      n.tx_cnt = r.tx_cnt + 22'h000001;
    end
    if (r.rx_cnt >= half_lim) begin
      n.rx_cnt = 22'h000000;
      rx_tick = 1'b1;
    end else begin
      n.rx_cnt = r.rx_cnt + 22'h000001;
    end
    // reading the data register pops the buffer
    if (rd_en && addr == `A_RXDAT) begin
      pop = 1'b1;
      n.wake = 1'b0;
      if (r.fcnt != 2'h0) begin
        n.fifo[0] = r.fifo[1];
        n.fcnt = r.fcnt - 2'h1;
      end
    end
    if (!continuous_receive_enable) begin
      n.receive_control_status[`B_OVERRUN_ERR] = 1'b0;
    end
    case (r.tx_st)
      TX_IDLE: begin
        n.ck_line = ckp;
        if (syncm) begin
          if ((continuous_receive_enable || (single_receive_enable && clock_source_select)) && !overrun_error_flag) begin
            n.tx_st = TX_SHIFT;
            n.s_rx = 1'b1;
            n.tx_bits = nb_rx;
            n.tx_cnt = 22'h000000;
          end else if (transmitter_enable && r.hv) begin
            n.tx_st = TX_SHIFT;
            n.s_rx = 1'b0;
            n.tx_sh = {5'h00, r.transmit_control_status[`B_TX_NINTH], r.hold};
            n.tx_bits = nb_tx;
            n.hv = 1'b0;
            n.tx_cnt = 22'h000000;
          end
        end else if (transmitter_enable && r.hv) begin
          n.tx_st = TX_SHIFT;
          n.tx_half = 1'b0;
          n.hv = 1'b0;
          n.tx_cnt = 22'h000000;
          n.brk = break_request;
          if (break_request) begin
            n.tx_sh = 14'h2000;
            n.tx_bits = `FRAME_BRK;
          end else if (tx9) begin
            n.tx_sh = {4'hF, r.transmit_control_status[`B_TX_NINTH], r.hold, 1'b0};
            n.tx_bits = `FRAME9;
          end else begin
            n.tx_sh = {5'h1F, r.hold, 1'b0};
            n.tx_bits = `FRAME8;
          end
        end
      end
      TX_SHIFT: begin
        if (syncm) begin
          if (clock_source_select && tx_tick) begin
            n.ck_line = ~r.ck_line;
          end
          if (shift_ev && !r.s_rx) begin
            n.tx_line = r.tx_sh[0];
            n.tx_sh = r.tx_sh >> 1;
          end
          if (samp_ev) begin
            if (r.s_rx) begin
              n.rx_sh = {rx_dat, r.rx_sh[8:1]};
            end
            if (r.tx_bits == 4'h1) begin
              sdone = 1'b1;
              n.tx_st = TX_IDLE;
              if (r.s_rx) begin
                push = 1'b1;
                ch = {1'b0, rx9 ? n.rx_sh : {1'b0, n.rx_sh[8:1]}};
                if (!continuous_receive_enable) begin
                  n.receive_control_status[`B_SINGLE_RX] = 1'b0;
                end
              end
            end else begin
              n.tx_bits = r.tx_bits - 4'h1;
            end
          end
        end else if (tx_tick) begin
          n.tx_half = ~r.tx_half;
          if (r.tx_half) begin
            if (r.tx_bits == 4'h1) begin
              tx_done = 1'b1;
              n.tx_st = TX_IDLE;
              if (r.brk) begin
                n.transmit_control_status[`B_BREAK_REQ] = 1'b0;
              end
            end else begin
              n.tx_sh = r.tx_sh >> 1;
              n.tx_bits = r.tx_bits - 4'h1;
            end
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
    case (r.rx_st)
      RX_IDLE: begin
        if (!syncm && rx_fall) begin
          if (autobaud_enable) begin
            n.rx_st = RX_ABD;
            // count includes the cycle of the first edge
            n.abd_cnt = 26'h0000001;
            n.abd_edges = 3'h0;
          end else if (wakeup_enable) begin
            n.wake = 1'b1;
            n.rx_st = RX_WAKE;
          end else if (continuous_receive_enable && !overrun_error_flag) begin
            n.rx_st = RX_START;
            n.rx_cnt = 22'h000000;
          end
        end
      end
      RX_START: begin
        if (rx_tick) begin
          n.rx_st = rx_dat ? RX_IDLE : RX_DATA;
          n.rx_half = 1'b0;
          n.rx_bits = 4'h0;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          n.rx_half = ~r.rx_half;
          if (r.rx_half) begin
            if (r.rx_bits == nb_rx) begin
              push = 1'b1;
              ch = {~rx_dat, rx9 ? r.rx_sh : {1'b0, r.rx_sh[8:1]}};
              n.rx_st = RX_IDLE;
            end else begin
              n.rx_sh = {rx_dat, r.rx_sh[8:1]};
              n.rx_bits = r.rx_bits + 4'h1;
            end
          end
        end
      end
      RX_WAKE: begin
        if (rx_rise) begin
          n.baud_control[`B_WAKEUP] = 1'b0;
          n.rx_st = RX_IDLE;
        end
      end
      RX_ABD: begin
        if (&r.abd_cnt) begin
          n.baud_control[`B_ABD_OVERFLOW] = 1'b1;
          n.baud_control[`B_AUTOBAUD] = 1'b0;
          n.rx_st = RX_IDLE;
        end else begin
          n.abd_cnt = r.abd_cnt + 26'h0000001;
        end
        if (rx_fall) begin
          if (r.abd_edges == `ABD_EDGES) begin
            {n.brg_hi, n.brg_lo} = abd_q[15:0];
            n.baud_control[`B_AUTOBAUD] = 1'b0;
            n.rx_st = RX_IDLE;
          end else begin
            n.abd_edges = r.abd_edges + 3'h1;
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase
    if (push) begin
      drop = address_detect_enable && rx9 && !syncm && !ch[8];
      if (drop) begin
        n.fcnt = n.fcnt;
      end else if (n.fcnt == `FIFO_DEPTH) begin
        n.receive_control_status[`B_OVERRUN_ERR] = 1'b1;
      end else begin
        n.fifo[n.fcnt[0]] = ch;
        n.fcnt = n.fcnt + 2'h1;
      end
    end
    if (wr_en) begin
      case (addr)
        `A_TRANSMIT_CONTROL_STATUS: n.transmit_control_status = (wr_data & `TXS_WMASK)
                            | (n.transmit_control_status & ~`TXS_WMASK);
        `A_RECEIVE_CONTROL_STATUS: n.receive_control_status = (wr_data & `RCS_WMASK)
                            | (n.receive_control_status & ~`RCS_WMASK);
        `A_BAUD: begin
          n.baud_control = (wr_data & `BDC_WMASK)
                      | (n.baud_control & ~`BDC_WMASK);
          if (wr_data[`B_AUTOBAUD]) begin
            n.baud_control[`B_ABD_OVERFLOW] = 1'b0;
          end
        end
        `A_BRGL: begin
          n.brg_lo = wr_data;
          n.tx_cnt = 22'h000000;
          n.rx_cnt = 22'h000000;
        end
        `A_HIGH_BAUD_SELECT: begin
          n.brg_hi = wr_data;
          n.tx_cnt = 22'h000000;
          n.rx_cnt = 22'h000000;
        end
        `A_TXDAT: begin
          n.hold = wr_data;
          n.hv = 1'b1;
        end
        default: n.hold = n.hold;
      endcase
    end
    if (!port_enable) begin
      n.tx_st = TX_IDLE;
      n.rx_st = RX_IDLE;
      n.fcnt = 2'h0;
      n.fifo = '0;
      n.wake = 1'b0;
      n.hv = 1'b0;
      n.receive_control_status[`B_OVERRUN_ERR] = 1'b0;
    end
    n.transmit_control_status[`B_SHIFT_EMPTY] = (n.tx_st == TX_IDLE);
    n.baud_control[`B_RX_IDLE] = (n.rx_st == RX_IDLE);
    n.rflag = (n.fcnt != 2'h0 && port_enable && (continuous_receive_enable || single_receive_enable))
              || n.wake;
    n.rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        `A_TRANSMIT_CONTROL_STATUS: n.rdata = r.transmit_control_status;
        `A_RECEIVE_CONTROL_STATUS: n.rdata = {r.receive_control_status[7:3], r.fifo[0][9], overrun_error_flag,
                             r.fifo[0][8]};
        `A_BAUD:  n.rdata = r.baud_control;
        `A_RXDAT: n.rdata = r.fifo[0][7:0];
        `A_BRGL:  n.rdata = r.brg_lo;
        `A_HIGH_BAUD_SELECT:  n.rdata = r.brg_hi;
        default:  n.rdata = 8'h00;
      endcase
    end
    n.ck_o = 1'b0;
    n.ck_oe_n = 1'b1;
    n.dt_o = 1'b0;
    n.dt_oe_n = 1'b1;
    if (port_enable) begin
      if (!syncm) begin
        n.ck_oe_n = 1'b0;
        n.ck_o = ((n.tx_st == TX_SHIFT) ? n.tx_sh[0] : 1'b1) ^ ckp;
      end else begin
        n.ck_oe_n = ~clock_source_select;
        n.ck_o = n.ck_line;
        n.dt_oe_n = ~(n.tx_st == TX_SHIFT && !n.s_rx);
        n.dt_o = n.tx_line ^ dpol;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  assign rd_data      = r.rdata;
  assign receive_flag = r.rflag;
  assign ck_out       = r.ck_o;
  assign ck_oe_n      = r.ck_oe_n;
  assign dt_out       = r.dt_o;
  assign dt_oe_n      = r.dt_oe_n;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_full_push;
    push && !drop && !pop && r.fcnt == `FIFO_DEPTH;
  endsequence
  sequence seq_brk_end;
    tx_done && r.brk && !wr_en;
  endsequence

  AST_SHIFT_REGISTER_EMPTY_DROPS: assert property (
    wr_en && addr == `A_TXDAT && r.tx_st == TX_IDLE && port_enable && transmitter_enable
    && !syncm ##1 port_enable && transmitter_enable && !wr_en
    |=> !r.transmit_control_status[`B_SHIFT_EMPTY])
    else $error("shift empty did not drop after load");
  AST_OVERRUN: assert property (seq_full_push |=> overrun_error_flag)
    else $error("overrun not flagged on third character");
  AST_FIFO_BOUND: assert property (r.fcnt <= `FIFO_DEPTH)
    else $error("buffer count above two");
  AST_OVERRUN_ERROR_FLAG_CLR: assert property (
    !continuous_receive_enable && r.tx_st == TX_IDLE && r.rx_st == RX_IDLE |=> !overrun_error_flag)
    else $error("overrun not cleared with receive enable low");
  AST_PORT_RESET: assert property (
    !port_enable |=> r.fcnt == 2'h0 && r.tx_st == TX_IDLE && r.ck_oe_n
    && r.dt_oe_n)
    else $error("port not held in reset while disabled");
  AST_SINGLE_RX: assert property (
    sdone && r.s_rx && !continuous_receive_enable && !wr_en |=> !single_receive_enable)
    else $error("single receive not cleared after reception");
  AST_BREAK_END: assert property (seq_brk_end |=> !break_request)
    else $error("break request not cleared after break");
  AST_ADDR_DROP: assert property (
    push && address_detect_enable && rx9 && !syncm && !ch[8] && !pop && port_enable
    |=> r.fcnt == $past(r.fcnt))
    else $error("non-address character entered buffer");
  AST_WAKE: assert property (
    r.rx_st == RX_WAKE && rx_rise && !wr_en && port_enable |=> !wakeup_enable)
    else $error("wake-up enable not cleared on rising edge");
  AST_RX_FLAG: assert property (
    r.fcnt != 2'h0 && port_enable && continuous_receive_enable && !pop && !wr_en |=> r.rflag)
    else $error("receive flag low with character waiting");
  AST_RX_ACTIVE: assert property (
    rx_fall && r.rx_st == RX_IDLE && continuous_receive_enable && !overrun_error_flag && !autobaud_enable && !wakeup_enable
    && !syncm && port_enable |=> !r.baud_control[`B_RX_IDLE])
    else $error("receive idle still set after start edge");

endmodule // serial_port

// ==== sim/line_partner.sv ====
`timescale 1ns/10ps
module line_partner #(
  parameter int BIT_NS = 48
) (
  output logic      line_out,
  input  wire logic line_in
);
  initial begin
    line_out = 1'b1;
  end

  // one frame: start, data lsb first, stop, one idle bit
  task automatic send(input logic [8:0] d, input int nbits,
                      input logic stop, input logic inv);
    int i;
    // step off the core clock edge
    #1;
    line_out = inv;
    #(BIT_NS);
    for (i = 0; i < nbits; i++) begin
      line_out = d[i] ^ inv;
      #(BIT_NS);
    end
    line_out = stop ^ inv;
    #(BIT_NS);
    line_out = ~inv;
    #(BIT_NS);
  endtask

  task automatic idle(input logic inv);
    #1;
    line_out = ~inv;
  endtask

  // waits for a start level, then samples mid-bit
  task automatic recv(input logic inv, output logic [7:0] d);
    int i;
    d = 8'h00;
    for (i = 0; i < 20000 && line_in !== inv; i++) #1;
    #(BIT_NS * 3 / 2);
    for (i = 0; i < 8; i++) begin
      d[i] = line_in ^ inv;
      #(BIT_NS);
    end
  endtask
endmodule // line_partner

// ==== sim/serial_port_test.sv ====
`timescale 1ns/10ps
`include "uart_cfg.svh"
module serial_port_test;
  logic        core_clk;
  logic        nrst;
  logic [2:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rd_data;
  logic        rx_dt_in;
  logic        ck_in;
  logic        dt_out;
  logic        dt_oe_n;
  logic        ck_out;
  logic        ck_oe_n;
  logic        receive_flag;
  logic [7:0]  v;
  logic [7:0]  v2;
  logic [31:0] r;
  logic [7:0]  b [3];
  integer      seed;
  int          i;
  int          n_mismatch;
  int          check_count;

  serial_port serial_port_inst (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .addr         (addr),
    .wr_data      (wr_data),
    .wr_en        (wr_en),
    .rd_en        (rd_en),
    .rd_data      (rd_data),
    .rx_dt_in     (rx_dt_in),
    .ck_in        (ck_in),
    .dt_out       (dt_out),
    .dt_oe_n      (dt_oe_n),
    .ck_out       (ck_out),
    .ck_oe_n      (ck_oe_n),
    .receive_flag (receive_flag)
  );

  line_partner line_partner_inst (
    .line_out (rx_dt_in),
    .line_in  (ck_out)
  );

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  function automatic logic [7:0] rcs(input logic [7:0] ctl, input logic fe,
                                     input logic oe, input logic n9);
    return {ctl[7:3], fe, oe, n9};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic wflag;
    int k;
    for (k = 0; k < 2000 && receive_flag !== 1'b1; k++) @(posedge core_clk);
    #1 chk({7'h00, receive_flag}, 8'h01);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task stop_test;
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #60000;
    n_mismatch++;
    stop_test;
  end

  initial begin
    seed = 32'hCE9AE0C1;
    nrst = 1'b0; addr = 3'h0; wr_data = 8'h00; wr_en = 1'b0;
    rd_en = 1'b0; ck_in = 1'b0; n_mismatch = 0; check_count = 0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    rd(`A_TRANSMIT_CONTROL_STATUS, v); chk(v, 8'h02);
    rd(`A_RECEIVE_CONTROL_STATUS, v); chk(v, 8'h00);
    rd(`A_BAUD, v);  chk(v, 8'h40);
    rd(3'h7, v);     chk(v, 8'h00);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(`A_HIGH_BAUD_SELECT, r[7:0]); wr(`A_BRGL, r[15:8]);
      wr(`A_BAUD, r[23:16] & 8'h3C);
      rd(`A_HIGH_BAUD_SELECT, v); chk(v, r[7:0]);
      rd(`A_BRGL, v); chk(v, r[15:8]);
      rd(`A_BAUD, v); chk(v, (r[23:16] & 8'h38) | 8'h40);
    end
    // bit time 4*(2+1) cycles, matching the partner
    wr(`A_HIGH_BAUD_SELECT, 8'h00); wr(`A_BRGL, 8'h02); wr(`A_BAUD, 8'h08);
    wr(`A_TRANSMIT_CONTROL_STATUS, 8'h24); wr(`A_RECEIVE_CONTROL_STATUS, 8'h90);
    pause(4);
    chk({7'h00, ck_oe_n}, 8'h00);
    chk({7'h00, ck_out}, 8'h01);
    for (i = 0; i < 2; i++) begin
      wr(`A_BAUD, i ? 8'h18 : 8'h08);
      r = $random(seed);
      wr(`A_TXDAT, r[7:0]);
      fork
        line_partner_inst.recv(i[0], v2);
        begin rd(`A_TRANSMIT_CONTROL_STATUS, v); chk(v, 8'h24); end
      join
      chk(v2, r[7:0]);
      pause(40);
    end
    wr(`A_BAUD, 8'h08);
    r = $random(seed);
    line_partner_inst.send({1'b0, r[7:0]}, 8, 1'b1, 1'b0);
    wflag;
    rd(`A_RECEIVE_CONTROL_STATUS, v); chk(v, rcs(8'h90, 1'b0, 1'b0, 1'b0));
    rd(`A_RXDAT, v); chk(v, r[7:0]);
    pause(2); chk({7'h00, receive_flag}, 8'h00);
    line_partner_inst.send({1'b0, r[15:8]}, 8, 1'b0, 1'b0);
    wflag;
    rd(`A_RECEIVE_CONTROL_STATUS, v); chk(v, rcs(8'h90, 1'b1, 1'b0, 1'b0));
    rd(`A_RXDAT, v); chk(v, r[15:8]);
    for (i = 0; i < 3; i++) begin
      r = $random(seed);
      b[i] = r[7:0];
      line_partner_inst.send({1'b0, b[i]}, 8, 1'b1, 1'b0);
    end
    rd(`A_RECEIVE_CONTROL_STATUS, v); chk(v, rcs(8'h90, 1'b0, 1'b1, 1'b0));
    rd(`A_RXDAT, v); chk(v, b[0]);
    rd(`A_RXDAT, v); chk(v, b[1]);
    wr(`A_RECEIVE_CONTROL_STATUS, 8'h80);
    rd(`A_RECEIVE_CONTROL_STATUS, v); chk(v, rcs(8'h80, 1'b0, 1'b0, 1'b0));
    wr(`A_RECEIVE_CONTROL_STATUS, 8'hD8);
    r = $random(seed);
    line_partner_inst.send({1'b0, r[7:0]}, 9, 1'b1, 1'b0);
    pause(4); chk({7'h00, receive_flag}, 8'h00);
    line_partner_inst.send({1'b1, r[15:8]}, 9, 1'b1, 1'b0);
    wflag;
    rd(`A_RECEIVE_CONTROL_STATUS, v); chk(v, rcs(8'hD8, 1'b0, 1'b0, 1'b1));
    rd(`A_RXDAT, v); chk(v, r[15:8]);
    // receiver off while the line polarity flips
    wr(`A_RECEIVE_CONTROL_STATUS, 8'h80); line_partner_inst.idle(1'b1);
    wr(`A_BAUD, 8'h28); wr(`A_RECEIVE_CONTROL_STATUS, 8'h90);
    line_partner_inst.send({1'b0, r[23:16]}, 8, 1'b1, 1'b1);
    wflag;
    rd(`A_RXDAT, v); chk(v, r[23:16]);
    wr(`A_RECEIVE_CONTROL_STATUS, 8'h80); line_partner_inst.idle(1'b0);
    wr(`A_BAUD, 8'h08); wr(`A_RECEIVE_CONTROL_STATUS, 8'h90);
    wr(`A_TRANSMIT_CONTROL_STATUS, 8'h2C); wr(`A_TXDAT, 8'h00);
    pause(60); chk({7'h00, ck_out}, 8'h00);
    pause(400);
    rd(`A_TRANSMIT_CONTROL_STATUS, v); chk(v, 8'h26);
    wr(`A_BAUD, 8'h0A);
    line_partner_inst.send(9'h000, 8, 1'b1, 1'b0);
    wflag;
    rd(`A_BAUD, v); chk(v, 8'h48);
    rd(`A_RXDAT, v);
    wr(`A_BRGL, 8'h00); wr(`A_BAUD, 8'h09);
    line_partner_inst.send(9'h055, 8, 1'b1, 1'b0);
    pause(20);
    rd(`A_BAUD, v); chk(v, 8'h48);
    rd(`A_BRGL, v); chk(v, 8'h02);
    // sync master single receive of an idle-high line
    wr(`A_RECEIVE_CONTROL_STATUS, 8'hA0); wr(`A_TRANSMIT_CONTROL_STATUS, 8'h90);
    pause(150);
    rd(`A_RECEIVE_CONTROL_STATUS, v); chk(v, 8'h80);
    rd(`A_RXDAT, v); chk(v, 8'hFF);
    wr(`A_TRANSMIT_CONTROL_STATUS, 8'hB0); pause(3);
    chk({7'h00, ck_oe_n}, 8'h00);
    // sync master transmit, data taken at falling clock
    r = $random(seed);
    wr(`A_TXDAT, r[7:0]);
    for (i = 0; i < 8; i++) begin
      @(negedge ck_out);
      #1 v[i] = dt_out;
    end
    chk({7'h00, dt_oe_n}, 8'h00);
    chk(v, r[7:0]);
    wr(`A_TRANSMIT_CONTROL_STATUS, 8'h30); pause(3);
    chk({7'h00, ck_oe_n}, 8'h01);
    wr(`A_RECEIVE_CONTROL_STATUS, 8'h00); pause(3);
    chk({6'h00, ck_oe_n, dt_oe_n}, 8'h03);
    stop_test;
  end
endmodule // serial_port_test
